// ### hw/torque_limit_pkg.sv
// constants for the torque mode, quadrant and current limit block
package torque_limit_pkg;
  // register byte addresses
  localparam logic [7:0] quad_one_addr     = 8'h00;
  localparam logic [7:0] quad_two_addr     = 8'h04;
  localparam logic [7:0] quad_three_addr   = 8'h08;
  localparam logic [7:0] quad_four_addr    = 8'h0c;
  localparam logic [7:0] auto_enable_addr  = 8'h10;
  localparam logic [7:0] delay_addr        = 8'h14;
  localparam logic [7:0] thresh_one_addr   = 8'h18;
  localparam logic [7:0] thresh_two_addr   = 8'h1c;
  localparam logic [7:0] slope_one_addr    = 8'h20;
  localparam logic [7:0] slope_two_addr    = 8'h24;
  localparam logic [7:0] flag_one_addr     = 8'h28;
  localparam logic [7:0] flag_two_addr     = 8'h2c;
  localparam logic [7:0] control_addr      = 8'h30;
  localparam logic [7:0] limit_one_addr    = 8'h34;
  localparam logic [7:0] limit_two_addr    = 8'h38;
  localparam logic [7:0] override_addr     = 8'h3c;
  // control register fields
  localparam int mode_lo_bit    = 0;
  localparam int mode_hi_bit    = 1;
  localparam int limit_sel_bit  = 2;
  // reset values
  localparam logic       quad_one_reset   = 1'b1;
  localparam logic       auto_reset       = 1'b0;
  localparam logic [7:0] delay_reset      = 8'h00;
  localparam logic [9:0] thresh_reset     = 10'h3e8;
  localparam logic [7:0] slope_reset      = 8'h00;
  localparam logic [9:0] limit_reset      = 10'h3e8;
  // slope scale: limit change = slope * speed change / 128
  localparam int slope_shift    = 7;
  // timing: one second at 250 MHz
  localparam int clock_hz       = 250_000_000;
  localparam int second_s       = 1;
  localparam int second_cycles  = clock_hz * second_s;
  // axi responses
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
endpackage

// ### hw/torque_quadrant_current_limit.sv
// torque mode, quadrant enables, secondary limit timer and current tapers
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: coiler mode only when both mode bits set
// R2: opposing torque and speed force zero speed reference
// R3: same polarity uses final speed demand as reference
// R4: coiler offset set slightly positive by operator
// R5: uncoiler offset slightly negative, scaling keeps demand high
// R6: line speed scaled to minimum diameter reel speed
// R7: quadrant one enable, resets enabled
// R8: quadrant two enable, default by drive type
// R9: quadrant three enable, default by drive type
// R10: quadrant four enable, default by drive type
// R11: disabled quadrant clamps current demand to zero
// R12: selector bit applies secondary limit to both bridges
// R13: auto enable sets selector after interval from run
// R14: interval in whole seconds, zero to 255
// R15: taper one threshold compare drives first flag
// R16: taper two threshold compare drives second flag
// R17: taper one reduces limit above threshold, slope/128
// R18: taper two further reduces limit above threshold
// R19: taper one used first and below taper two
// R20: overriding limit is lower of taper and secondary
module torque_quadrant_current_limit #(
  parameter logic        FOUR_QUADRANT   = 1'b1,  // drive type strap
  parameter int unsigned CYCLES_PER_SEC  = torque_limit_pkg::second_cycles
) (
  input  wire  logic              aclk,
  input  wire  logic              aresetn,
  input  wire  logic              s_axi_awvalid,
  output var   logic              s_axi_awready,
  input  wire  logic [7:0]        s_axi_awaddr,
  input  wire  logic              s_axi_wvalid,
  output var   logic              s_axi_wready,
  input  wire  logic [31:0]       s_axi_wdata,
  input  wire  logic [3:0]        s_axi_wstrb,
  output var   logic              s_axi_bvalid,
  input  wire  logic              s_axi_bready,
  output var   logic [1:0]        s_axi_bresp,
  input  wire  logic              s_axi_arvalid,
  output var   logic              s_axi_arready,
  input  wire  logic [7:0]        s_axi_araddr,
  output var   logic              s_axi_rvalid,
  input  wire  logic              s_axi_rready,
  output var   logic [31:0]       s_axi_rdata,
  output var   logic [1:0]        s_axi_rresp,
  input  wire  logic              run_command,         // level, high while running
  input  wire  logic signed [10:0] speed_feedback,     // -1000..+1000
  input  wire  logic signed [10:0] final_speed_demand, // -1000..+1000
  input  wire  logic signed [10:0] torque_demand,      // sign used for polarity
  input  wire  logic signed [10:0] current_demand,     // from the speed loop
  output var   logic signed [10:0] speed_reference,    // to the speed loop
  output var   logic signed [10:0] limited_current_demand,
  output var   logic [9:0]        overriding_limit,
  output var   logic              first_taper_exceeded,
  output var   logic              second_taper_exceeded,
  output var   logic              second_limit_active
);

  typedef enum logic [1:0] {
    timer_idle  = 2'b00,  // waiting for a run command
    timer_count = 2'b01,  // counting seconds since run
    timer_done  = 2'b10   // fired, or run ended the wait
  } timer_state_t;

  // byte lane merge
  function automatic logic [31:0] merge(input logic [31:0] old_word,
                                        input logic [31:0] new_word,
                                        input logic [3:0]  strb);
    logic [31:0] result;
    result = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return result;
  endfunction

  // magnitude of a signed demand, saturated into ten bits
  function automatic logic [9:0] magnitude(input logic signed [10:0] value);
    logic [10:0] mag;
    mag = value[10] ? 11'(-value) : 11'(value);
    return mag[10] ? 10'h3ff : mag[9:0];
  endfunction

  // slope times speed over threshold, divided by 128
  function automatic logic [11:0] taper_cut(input logic [9:0] speed_mag,
                                            input logic [9:0] thresh,
                                            input logic [7:0] slope);
    logic [17:0] product;
    product = 18'h0;
    if (speed_mag > thresh) begin
      product = 18'(slope) * 18'(speed_mag - thresh);
    end
    return 12'(product[17:torque_limit_pkg::slope_shift]);
  endfunction

  // registers
  logic              quad_one;       // quadrant one enable
  logic              quad_two;
  logic              quad_three;
  logic              quad_four;
  logic              auto_enable;    // automatic secondary limit change
  logic [7:0]        delay_seconds;
  logic [9:0]        thresh_one;
  logic [9:0]        thresh_two;
  logic [7:0]        slope_one;
  logic [7:0]        slope_two;
  logic [1:0]        torque_mode;    // two mode selection bits
  logic              limit_select;   // secondary limit selector
  logic [9:0]        limit_one;      // primary limit, taper datum
  logic [9:0]        limit_two;      // secondary limit
  // timer
  timer_state_t      timer_state;
  logic [31:0]       tick_count;     // cycles within the current second
  logic [7:0]        sec_count;      // whole seconds elapsed
  logic              run_prev;       // for run edge detect

  // bus decode
  wire               write_take = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready
                                  & ~s_axi_bvalid;
  wire               read_take  = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
  wire               wr_any     = write_take;
  wire [7:0]         wa         = s_axi_awaddr;
  wire               write_known = (wa[1:0] == 2'b00) && (wa <= torque_limit_pkg::override_addr);
  wire               read_known  = (s_axi_araddr[1:0] == 2'b00)
                                   && (s_axi_araddr <= torque_limit_pkg::override_addr);

  // merge only the strobed lanes
  logic [31:0]       cur_word;
  always_comb cur_word = read_word(wa);
  wire [31:0]        wr_word    = merge(cur_word, s_axi_wdata, s_axi_wstrb);

  // read mux for bus reads and write merges
  function automatic logic [31:0] read_word(input logic [7:0] addr);
    case (addr)
      torque_limit_pkg::quad_one_addr:    read_word = {31'h0, quad_one};
      torque_limit_pkg::quad_two_addr:    read_word = {31'h0, quad_two};
      torque_limit_pkg::quad_three_addr:  read_word = {31'h0, quad_three};
      torque_limit_pkg::quad_four_addr:   read_word = {31'h0, quad_four};
      torque_limit_pkg::auto_enable_addr: read_word = {31'h0, auto_enable};
      torque_limit_pkg::delay_addr:       read_word = {24'h0, delay_seconds};
      torque_limit_pkg::thresh_one_addr:  read_word = {22'h0, thresh_one};
      torque_limit_pkg::thresh_two_addr:  read_word = {22'h0, thresh_two};
      torque_limit_pkg::slope_one_addr:   read_word = {24'h0, slope_one};
      torque_limit_pkg::slope_two_addr:   read_word = {24'h0, slope_two};
      torque_limit_pkg::flag_one_addr:    read_word = {31'h0, first_taper_exceeded};
      torque_limit_pkg::flag_two_addr:    read_word = {31'h0, second_taper_exceeded};
      torque_limit_pkg::control_addr:     read_word = {29'h0, limit_select, torque_mode};
      torque_limit_pkg::limit_one_addr:   read_word = {22'h0, limit_one};
      torque_limit_pkg::limit_two_addr:   read_word = {22'h0, limit_two};
      torque_limit_pkg::override_addr:    read_word = {22'h0, overriding_limit};
      default:                            read_word = 32'h0;
    endcase
  endfunction

  // write strobe for the control register
  wire               wr_ctrl    = wr_any && wa == torque_limit_pkg::control_addr;

  // timer: run edge and the end of a second
  wire               run_rise   = run_command & ~run_prev;
  wire               sec_tick   = (tick_count == CYCLES_PER_SEC - 1);
  wire               timer_fire = (timer_state == timer_count) && auto_enable
                                  && (sec_count == delay_seconds);     // [R13] [R14]
  // selector after this cycle's write
  wire               sel_written = wr_ctrl ? wr_word[torque_limit_pkg::limit_sel_bit]
                                           : limit_select;
  wire               next_limit_select = timer_fire | sel_written;    // set beats clear [R13]

  // coiler mode and speed reference
  wire               coiler_mode = (torque_mode == 2'b11);              // [R1]
  wire               opposing    = torque_demand[10] != speed_feedback[10];
  wire signed [10:0] next_speed_ref = (coiler_mode && opposing) ? 11'sh000 // [R2]
                                      : final_speed_demand;           // [R3]

  // taper and overriding limit
  wire [9:0]         speed_mag   = magnitude(speed_feedback);         // either direction
  wire [11:0]        cut_one     = taper_cut(speed_mag, thresh_one, slope_one); // [R17]
  wire [11:0]        cut_two     = taper_cut(speed_mag, thresh_two, slope_two); // [R18]
  wire [12:0]        cut_total   = 13'(cut_one) + 13'(cut_two);
  wire [9:0]         taper_limit = (cut_total >= 13'(limit_one)) ? 10'h000
                                   : 10'(13'(limit_one) - cut_total);
  wire [9:0]         next_override = (limit_select && limit_two < taper_limit)
                                     ? limit_two : taper_limit;       // [R12] [R20]

  // quadrant of the demand; zero speed counts as forward
  wire               speed_neg   = speed_feedback[10];
  wire               demand_neg  = current_demand[10];
  wire               quad_allowed = (!speed_neg && !demand_neg) ? quad_one   // [R7]
                                  : ( speed_neg && !demand_neg) ? quad_two   // [R8]
                                  : ( speed_neg &&  demand_neg) ? quad_three // [R9]
                                  : quad_four;                               // [R10]
  wire [9:0]         demand_mag  = magnitude(current_demand);
  wire [9:0]         clamp_mag   = (demand_mag > next_override) ? next_override : demand_mag;
  wire signed [10:0] clamped     = demand_neg ? -$signed({1'b0, clamp_mag})
                                              : $signed({1'b0, clamp_mag});
  wire signed [10:0] next_demand = quad_allowed ? clamped : 11'sh000;     // [R11]

  // axi write channel: both address and data are taken in one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= torque_limit_pkg::resp_okay;
    end else begin
      s_axi_awready <= write_take;
      s_axi_wready  <= write_take;
      if (write_take) begin
        s_axi_bvalid <= 1'b1;
        // unmapped or misaligned: error
        s_axi_bresp  <= write_known ? torque_limit_pkg::resp_okay
                                    : torque_limit_pkg::resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi read channel: data sampled at the accept edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= torque_limit_pkg::resp_okay;
    end else begin
      s_axi_arready <= read_take;
      if (read_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= read_known ? read_word(s_axi_araddr) : 32'h0;
        s_axi_rresp  <= read_known ? torque_limit_pkg::resp_okay
                                   : torque_limit_pkg::resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // quadrant and taper settings; flags ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad_one      <= torque_limit_pkg::quad_one_reset;             // [R7]
      quad_two      <= FOUR_QUADRANT;                                // [R8]
      quad_three    <= FOUR_QUADRANT;                                // [R9]
      quad_four     <= FOUR_QUADRANT;                                // [R10]
      auto_enable   <= torque_limit_pkg::auto_reset;                 // [R13]
      delay_seconds <= torque_limit_pkg::delay_reset;                // [R14]
      thresh_one    <= torque_limit_pkg::thresh_reset;               // [R15]
      thresh_two    <= torque_limit_pkg::thresh_reset;               // [R16]
      slope_one     <= torque_limit_pkg::slope_reset;
      slope_two     <= torque_limit_pkg::slope_reset;
    end else if (wr_any && write_known) begin
      case (wa)
        torque_limit_pkg::quad_one_addr:    quad_one      <= wr_word[0];
        torque_limit_pkg::quad_two_addr:    quad_two      <= wr_word[0];
        torque_limit_pkg::quad_three_addr:  quad_three    <= wr_word[0];
        torque_limit_pkg::quad_four_addr:   quad_four     <= wr_word[0];
        torque_limit_pkg::auto_enable_addr: auto_enable   <= wr_word[0];
        torque_limit_pkg::delay_addr:       delay_seconds <= wr_word[7:0];
        // thresholds above full scale saturate at 1000
        torque_limit_pkg::thresh_one_addr:
          thresh_one <= (wr_word[9:0] > torque_limit_pkg::thresh_reset)
                        ? torque_limit_pkg::thresh_reset : wr_word[9:0];
        torque_limit_pkg::thresh_two_addr:
          thresh_two <= (wr_word[9:0] > torque_limit_pkg::thresh_reset)
                        ? torque_limit_pkg::thresh_reset : wr_word[9:0];
        torque_limit_pkg::slope_one_addr:   slope_one     <= wr_word[7:0];
        torque_limit_pkg::slope_two_addr:   slope_two     <= wr_word[7:0];
        default: ;                          // control and limit words handled below
      endcase
    end
  end

  // mode bits and current limits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      torque_mode <= 2'b00;
      limit_one   <= torque_limit_pkg::limit_reset;
      limit_two   <= torque_limit_pkg::limit_reset;
    end else if (wr_any) begin
      if (wr_ctrl) begin
        torque_mode <= {wr_word[torque_limit_pkg::mode_hi_bit],
                        wr_word[torque_limit_pkg::mode_lo_bit]};
      end
      if (wa == torque_limit_pkg::limit_one_addr) begin
        limit_one <= (wr_word[9:0] > torque_limit_pkg::limit_reset)
                     ? torque_limit_pkg::limit_reset : wr_word[9:0];
      end
      if (wa == torque_limit_pkg::limit_two_addr) begin
        limit_two <= (wr_word[9:0] > torque_limit_pkg::limit_reset)
                     ? torque_limit_pkg::limit_reset : wr_word[9:0];
      end
    end
  end

  // secondary limit selector: timer set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      limit_select <= 1'b0;
    end else begin
      limit_select <= next_limit_select;                              // [R12]
    end
  end

  // run timer: restarts on a run edge, stops when run drops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_state <= timer_idle;
      tick_count  <= 32'h0;
      sec_count   <= 8'h00;
      run_prev    <= 1'b0;
    end else begin
      run_prev <= run_command;
      case (timer_state)
        timer_idle: begin
          if (run_rise) begin
            timer_state <= timer_count;
            tick_count  <= 32'h0;
            sec_count   <= 8'h00;
          end
        end
        timer_count: begin
          if (!run_command || timer_fire) begin
            timer_state <= timer_done;
          end else if (sec_tick) begin
            tick_count <= 32'h0;
            // a delay of 255 is reached before this counter wraps
            sec_count  <= sec_count + 8'h01;                          // [R14]
          end else begin
            tick_count <= tick_count + 32'h1;
          end
        end
        timer_done: begin
          // rearm once run ends
          if (!run_command) begin
            timer_state <= timer_idle;
          end
        end
        default: timer_state <= timer_idle;
      endcase
    end
  end

  // registered outputs toward the loops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_reference        <= 11'sh000;
      limited_current_demand <= 11'sh000;
      overriding_limit       <= torque_limit_pkg::limit_reset;
      first_taper_exceeded   <= 1'b0;
      second_taper_exceeded  <= 1'b0;
      second_limit_active    <= 1'b0;
    end else begin
      speed_reference        <= next_speed_ref;                       // [R2] [R3]
      limited_current_demand <= next_demand;                          // [R11] [R20]
      overriding_limit       <= next_override;                        // [R20]
      first_taper_exceeded   <= speed_mag > thresh_one;               // [R15]
      second_taper_exceeded  <= speed_mag > thresh_two;               // [R16]
      second_limit_active    <= limit_select;                         // [R12]
    end
  end

endmodule // torque_quadrant_current_limit

`default_nettype wire

// ### testbench/tb_torque_quadrant_current_limit.sv
// register and data path bench for the torque and current limit block
`timescale 1ns/1ps
`default_nettype none
module tb_torque_quadrant_current_limit;
  logic aclk = 1'b0, aresetn = 1'b0, run_command = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic signed [10:0] speed_feedback = '0, final_speed_demand = '0;
  logic signed [10:0] torque_demand = '0, current_demand = '0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic signed [10:0] speed_reference, limited_current_demand;
  wire logic [9:0] overriding_limit;
  wire logic first_taper_exceeded, second_taper_exceeded, second_limit_active;
  int n_mismatch = 0;                 // mismatches seen
  int check_count = 0;                // comparisons made
  logic [31:0] d;                     // last read data
  logic [1:0]  r;                     // last response
  // reset values by address
  logic [31:0] rst_v [16] = '{1, 1, 1, 1, 0, 0, 'h3e8, 'h3e8, 0, 0, 0, 0, 0, 'h3e8, 'h3e8, 'h3e8};
  // short second for the timer test
  torque_quadrant_current_limit #(.FOUR_QUADRANT(1'b1), .CYCLES_PER_SEC(10)) uut (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .run_command,
    .speed_feedback, .final_speed_demand, .torque_demand, .current_demand, .speed_reference,
    .limited_current_demand, .overriding_limit, .first_taper_exceeded, .second_taper_exceeded,
    .second_limit_active);
  // 4 ns clock
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // each channel held until its own ready
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= a;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    {s_axi_arvalid, s_axi_rready} <= 2'b00;
  endtask
  // outputs follow inputs one edge later
  task automatic settle;
    repeat (2) @(posedge aclk);
    #1;
  endtask
  task close_out;
    if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog, far beyond the test length
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chk(overriding_limit, 32'h3e8);
    for (int i = 0; i < 16; i++) begin
      rd(8'(i * 4));
      chk(d, rst_v[i]);
    end
    rd(8'h40);
    chk(32'(r), 32'h2);
    wr(torque_limit_pkg::flag_one_addr, 32'h1);
    chk(32'(r), 32'h0);
    rd(torque_limit_pkg::flag_one_addr);
    chk(d, 32'h0);
    // each quadrant blocked alone, then restored
    for (int q = 0; q < 4; q++) begin
      @(posedge aclk);
      speed_feedback <= (q == 1 || q == 2) ? -11'sd50 : 11'sd50;
      current_demand <= (q >= 2) ? -11'sd100 : 11'sd100;
      wr(8'(q * 4), 32'h0);
      settle;
      chk(32'(limited_current_demand), 32'h0);
      wr(8'(q * 4), 32'h1);
      settle;
      chk(32'(limited_current_demand), (q >= 2) ? 32'hffffff9c : 32'h64);
    end
    // one mode bit, then both
    @(posedge aclk);
    speed_feedback <= 11'sd100;
    final_speed_demand <= 11'sd200;
    torque_demand <= -11'sd5;
    wr(torque_limit_pkg::control_addr, 32'h1);
    settle;
    chk(32'(speed_reference), 32'd200);
    wr(torque_limit_pkg::control_addr, 32'h3);
    settle;
    chk(32'(speed_reference), 32'd0);
    @(posedge aclk);
    torque_demand <= 11'sd5;
    settle;
    chk(32'(speed_reference), 32'd200);
    // tapers in reverse rotation: 1000 - 200*128/128 - 100*64/128
    wr(torque_limit_pkg::control_addr, 32'h0);
    wr(torque_limit_pkg::thresh_one_addr, 32'd100);
    wr(torque_limit_pkg::slope_one_addr, 32'd128);
    speed_feedback <= -11'sd300;
    current_demand <= 11'sd900;
    settle;
    chk(overriding_limit, 32'd800);
    chk({first_taper_exceeded, second_taper_exceeded}, 32'h2);
    wr(torque_limit_pkg::thresh_two_addr, 32'd200);
    wr(torque_limit_pkg::slope_two_addr, 32'd64);
    settle;
    chk(overriding_limit, 32'd750);
    chk(32'(limited_current_demand), 32'd750);
    rd(torque_limit_pkg::flag_two_addr);
    chk(d, 32'h1);
    // secondary limit below, then above taper
    wr(torque_limit_pkg::limit_two_addr, 32'd500);
    wr(torque_limit_pkg::control_addr, 32'h4);
    settle;
    chk(overriding_limit, 32'd500);
    chk(second_limit_active, 32'h1);
    wr(torque_limit_pkg::limit_two_addr, 32'd900);
    settle;
    chk(overriding_limit, 32'd750);
    // automatic change two seconds after run
    wr(torque_limit_pkg::control_addr, 32'h0);
    wr(torque_limit_pkg::auto_enable_addr, 32'h1);
    wr(torque_limit_pkg::delay_addr, 32'h2);
    rd(torque_limit_pkg::delay_addr);
    chk(d, 32'h2);
    @(posedge aclk);
    run_command <= 1'b1;
    repeat (22) @(posedge aclk);
    #1;
    chk(second_limit_active, 32'h0);
    @(posedge aclk);
    #1;
    chk(second_limit_active, 32'h1);
    close_out;
  end
endmodule // tb_torque_quadrant_current_limit
`default_nettype wire

// ### testbench/torque_limit_assertions.sv
// port-level checker for the torque mode and current limit block
`timescale 1ns/1ps
`default_nettype none
module torque_limit_checker (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic signed [10:0] speed_feedback,
  input wire logic signed [10:0] final_speed_demand,
  input wire logic signed [10:0] torque_demand,
  input wire logic signed [10:0] current_demand,
  input wire logic signed [10:0] speed_reference,
  input wire logic signed [10:0] limited_current_demand,
  input wire logic [9:0]        overriding_limit,
  input wire logic              first_taper_exceeded,
  input wire logic              second_taper_exceeded
);
  // one clock domain
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers come one edge after the take
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // reference is the demand or zero
  a_ref_choice: assert property ($past(aresetn) |-> speed_reference == 0 ||
    speed_reference == $past(final_speed_demand)) else $error("speed reference invalid");
  a_ref_same_sign: assert property (torque_demand[10] == speed_feedback[10]
    |=> speed_reference == $past(final_speed_demand)) else $error("reference not demand");
  // demand magnitude within the limit
  a_demand_clamp: assert property ((limited_current_demand[10] ? -limited_current_demand :
    limited_current_demand) <= overriding_limit) else $error("demand above limit");
  a_demand_sign: assert property ($past(aresetn) |-> limited_current_demand == 0 ||
    limited_current_demand[10] == $past(current_demand[10])) else $error("demand sign flipped");
  a_limit_ceiling: assert property (overriding_limit <= 10'h3e8) else $error("limit too high");
  a_still_flags: assert property (speed_feedback == 0 |=> !first_taper_exceeded &&
    !second_taper_exceeded) else $error("flag set at standstill");
endmodule // torque_limit_checker
bind torque_quadrant_current_limit torque_limit_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .speed_feedback,
  .final_speed_demand, .torque_demand, .current_demand, .speed_reference, .limited_current_demand,
  .overriding_limit, .first_taper_exceeded, .second_taper_exceeded);
`default_nettype wire
